// >>> hdl/apm_defs.svh
// Constants for the automatic power management idle timers.
// Included by every design file except the package; definitions only.
`ifndef APM_DEFS_SVH
`define APM_DEFS_SVH

// Configuration register indexes
`define APM_IDX_ENABLES   8'h32
`define APM_IDX_ACPI_BASE 8'h33
`define APM_IDX_GP_BASE   8'h34
`define APM_IDX_UART_A    8'h35
`define APM_IDX_UART_B    8'h36
`define APM_IDX_FLOPPY    8'h37
`define APM_IDX_PRINTER   8'h38
`define APM_IDX_STANDBY   8'h39
`define APM_IDX_UNIT      8'h3A
`define APM_IDX_IDLE_STS  8'h40
`define APM_IDX_WAKE_STS  8'h41

// Field positions and writable masks
`define APM_BIT_CHIP_EN   7
`define APM_BIT_UNIT      5
`define APM_MASK_ENABLES  8'h8F
`define APM_MASK_ACPI     8'hFC
`define APM_MASK_GP       8'hFE
`define APM_MASK_UNIT     8'h20
`define APM_RST_BYTE      8'h00
`define APM_ZERO_COUNT    8'h00

// Function slots, equal to their enable and status bit positions
`define APM_FN_UART_B     0
`define APM_FN_UART_A     1
`define APM_FN_FLOPPY     2
`define APM_FN_PRINTER    3
`define APM_NUM_FN        4

// Address block offsets
`define APM_ACPI_CNT_OFS  10'h004
`define APM_ACPI_TMR_OFS  10'h008
`define APM_GPE1_OFS      10'h004

// Timing
`define APM_CLK_HZ        40000000
`define APM_TICK_TIME_S   1
`define APM_SECS_PER_MIN  6'd60

`endif

// >>> hdl/apm_pkg.sv
// Types shared by the power management idle timer design.
// Assumes apm_defs.svh is on the include path.
package apm_pkg;
  typedef enum logic {APM_WORK, APM_SLEEP} apm_state_t;
endpackage

// >>> hdl/apm_unit_tick.sv
// One-second or one-minute tick for all idle timers.
// Assumes a free-running ref_clk; SEC_CYCLES may be shortened in simulation.
`timescale 1ns/1ps
`default_nettype none
`include "apm_defs.svh"
module apm_unit_tick #(
  parameter int unsigned SEC_CYCLES = `APM_TICK_TIME_S * `APM_CLK_HZ
) (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic sys_rst,
  // Unit select: 0 second, 1 minute
  input  wire logic minuteSel,
  // One-cycle pulse per unit
  output logic      tick
);
  logic [31:0] cycCount;
  logic [31:0] next_cycCount;
  logic [5:0]  secCount;
  logic [5:0]  next_secCount;
  logic        next_tick;

  always_comb begin
    next_cycCount = cycCount + 32'h0000_0001;
    next_secCount = secCount;
    next_tick     = 1'b0;
    if (cycCount >= SEC_CYCLES - 32'h0000_0001) begin
      next_cycCount = 32'h0000_0000;
      if (!minuteSel || secCount >= `APM_SECS_PER_MIN - 6'd1) begin
        next_secCount = 6'h00;
        next_tick     = 1'b1; // see RULE18
      end else begin
        next_secCount = secCount + 6'h01;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cycCount <= 32'h0000_0000;
      secCount <= 6'h00;
      tick     <= 1'b0;
    end else begin
      cycCount <= next_cycCount;
      secCount <= next_secCount;
      tick     <= next_tick;
    end
  end
endmodule // apm_unit_tick
`default_nettype wire

// >>> hdl/apm_idle_timer.sv
// Idle timer and working/sleeping state for one function or the whole chip.
// Assumes wakeEvent and tick are on ref_clk; wakeEvent may be a level.
`timescale 1ns/1ps
`default_nettype none
`include "apm_defs.svh"
module apm_idle_timer (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  // Control
  input  wire logic       tick,
  input  wire logic       pmEnable,
  input  wire logic [7:0] initCount,
  input  wire logic       wakeEvent,
  // State and events
  output logic            asleep,
  output logic            expired,
  output logic            woke
);
  apm_pkg::apm_state_t state;
  apm_pkg::apm_state_t next_state;
  logic [7:0]          count;
  logic [7:0]          next_count;
  logic                next_expired;
  logic                next_woke;

  always_comb begin
    next_state   = state;
    next_count   = count;
    next_expired = 1'b0;
    next_woke    = 1'b0;
    if (!pmEnable) begin
      // Without management the function simply stays awake
      next_state = apm_pkg::APM_WORK;
      next_count = initCount;
    end else if (wakeEvent) begin
      next_state = apm_pkg::APM_WORK; // see RULE7
      next_count = initCount;         // see RULE21
      next_woke  = 1'b1;
    end else if (state == apm_pkg::APM_WORK && initCount != `APM_ZERO_COUNT && tick) begin // see RULE12
      if (count <= 8'h01) begin
        next_state   = apm_pkg::APM_SLEEP;
        next_count   = `APM_ZERO_COUNT;
        next_expired = 1'b1;
      end else begin
        next_count = count - 8'h01;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state   <= apm_pkg::APM_WORK;
      count   <= `APM_ZERO_COUNT;
      expired <= 1'b0;
      woke    <= 1'b0;
    end else begin
      state   <= next_state;
      count   <= next_count;
      expired <= next_expired;
      woke    <= next_woke;
    end
  end

  assign asleep = (state == apm_pkg::APM_SLEEP);

  property p_zero_holds; // see RULE12
    @(posedge ref_clk) disable iff (sys_rst)
    (pmEnable && initCount == 8'h00 && !wakeEvent) |=> $stable(asleep);
  endproperty
  a_zero_holds: assert property (p_zero_holds) else $error("zero count changed state");

  property p_wake_reload; // see RULE21
    @(posedge ref_clk) disable iff (sys_rst)
    (pmEnable && wakeEvent) |=> (!asleep && woke && count == $past(initCount));
  endproperty
  a_wake_reload: assert property (p_wake_reload) else $error("wake did not reload");

  property p_expire_sleeps; // see RULE8
    @(posedge ref_clk) disable iff (sys_rst)
    expired |-> (asleep && $past(!asleep) && $past(count) <= 8'h01);
  endproperty
  a_expire_sleeps: assert property (p_expire_sleeps) else $error("bad expiry");
endmodule // apm_idle_timer
`default_nettype wire

// >>> hdl/apm_power_idle.sv
// Automatic power management: registers, four function idle timers, standby.
// Assumes config strobes and activity pulses come from logic on ref_clk.
//
// Operation
// RULE1: Enable bit 7 switches all power management functions on or off.
// RULE2: A function is managed only with its own bit and chip enable set.
// RULE3: Software places event block base 100H..3F0H, 16-byte aligned.
// RULE4: Control block decodes at event base plus four, timer at plus eight.
// RULE5: Software places general event base 100H..3F8H, 8-byte aligned.
// RULE6: Second general event block sits at first base plus four.
// RULE7: Any access, interrupt or input to a function wakes it.
// RULE8: Serial A reloads its count on wake, sleeps when it reaches zero.
// RULE9: Serial B reloads its count on wake, sleeps when it reaches zero.
// RULE10: Floppy reloads its count on wake, sleeps when it reaches zero.
// RULE11: Printer reloads its count on wake, sleeps when it reaches zero.
// RULE12: A zero count disables power down; the function keeps its state.
// RULE13: Idle count applies only with function and chip enables set.
// RULE14: All timers count in seconds or minutes, chosen by one bit.
// RULE15: With all four functions asleep, standby count loads and counts down.
// RULE16: Standby reaching zero sleeps the chip; zero count disables this.
// RULE17: Standby count applies only while chip enable is set.
// RULE18: Unit bit 5 at zero picks seconds, at one picks minutes.
// RULE19: Expiry sets an idle status bit; writing one clears it.
// RULE20: Waking sets a wake status bit and reloads the idle timer.
// RULE21: A wake while counting restarts from the programmed count.
`timescale 1ns/1ps
`default_nettype none
`include "apm_defs.svh"
module apm_power_idle #(
  parameter int unsigned SEC_CYCLES = `APM_TICK_TIME_S * `APM_CLK_HZ
) (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  // Configuration index/data ports
  input  wire logic       configMode,
  input  wire logic       cfgIndexWr,
  input  wire logic       cfgDataWr,
  input  wire logic [7:0] cfgWrData,
  output logic      [7:0] cfgRdData,
  // Function activity, bit per function
  input  wire logic [3:0] fnActivity,
  // Power states
  output logic      [3:0] fnSleep,
  output logic            chipSleep,
  // Address block decode
  output logic            acpiDecodeEn,
  output logic      [9:0] acpiEvtBase,
  output logic      [9:0] acpiCntBase,
  output logic      [9:0] acpiTmrBase,
  output logic      [9:0] gpe0Base,
  output logic      [9:0] gpe1Base
);
  // Configuration state
  logic [7:0] cfgIndex;
  logic [7:0] next_cfgIndex;
  logic [7:0] pmEnables;
  logic [7:0] next_pmEnables;
  logic [7:0] acpiBaseReg;
  logic [7:0] next_acpiBaseReg;
  logic [7:0] gpBaseReg;
  logic [7:0] next_gpBaseReg;
  logic [7:0] idleInit [0:`APM_NUM_FN-1];
  logic [7:0] next_idleInit [0:`APM_NUM_FN-1];
  logic [7:0] standbyInit;
  logic [7:0] next_standbyInit;
  logic [7:0] unitReg;
  logic [7:0] next_unitReg;
  logic [3:0] idleSts;
  logic [3:0] next_idleSts;
  logic [3:0] wakeSts;
  logic [3:0] next_wakeSts;
  logic [7:0] next_cfgRdData;
  logic [9:0] next_acpiEvtBase;
  logic [9:0] next_gpe0Base;
  logic       next_acpiDecodeEn;

  // Timer wiring
  logic       unitTick;
  logic       chipEnable;
  logic       dataWrite;
  logic [3:0] fnEnable;
  logic [3:0] fnAsleep;
  logic [3:0] fnExpired;
  logic [3:0] fnWoke;
  logic       allAsleep;
  logic       standbyAsleep;

  assign chipEnable = pmEnables[`APM_BIT_CHIP_EN]; // see RULE1
  assign dataWrite  = configMode && cfgDataWr;
  assign allAsleep  = &fnAsleep;

  apm_unit_tick #(
    .SEC_CYCLES (SEC_CYCLES)
  ) u_tick (
    .ref_clk   (ref_clk),
    .sys_rst   (sys_rst),
    .minuteSel (unitReg[`APM_BIT_UNIT]), // see RULE14
    .tick      (unitTick)
  );

  // One timer per function; slot index equals the enable bit position
  genvar g;
  generate
    for (g = 0; g < `APM_NUM_FN; g++) begin : g_fn
      assign fnEnable[g] = chipEnable && pmEnables[g]; // see RULE2 see RULE13
      apm_idle_timer u_timer (
        .ref_clk   (ref_clk),
        .sys_rst   (sys_rst),
        .tick      (unitTick),
        .pmEnable  (fnEnable[g]),
        .initCount (idleInit[g]),
        .wakeEvent (fnActivity[g]), // see RULE7 see RULE20
        .asleep    (fnAsleep[g]),   // see RULE8 see RULE9 see RULE10 see RULE11
        .expired   (fnExpired[g]),
        .woke      (fnWoke[g])
      );
    end
  endgenerate

  // Standby is held reloaded while any function is awake
  apm_idle_timer u_standby (
    .ref_clk   (ref_clk),
    .sys_rst   (sys_rst),
    .tick      (unitTick),
    .pmEnable  (chipEnable),   // see RULE17
    .initCount (standbyInit),  // see RULE16
    .wakeEvent (!allAsleep),   // see RULE15
    .asleep    (standbyAsleep),
    .expired   (),
    .woke      ()
  );

  assign fnSleep   = fnAsleep;
  assign chipSleep = standbyAsleep;

  always_comb begin
    next_cfgIndex    = cfgIndex;
    next_pmEnables   = pmEnables;
    next_acpiBaseReg = acpiBaseReg;
    next_gpBaseReg   = gpBaseReg;
    next_standbyInit = standbyInit;
    next_unitReg     = unitReg;
    for (int i = 0; i < `APM_NUM_FN; i++) begin
      next_idleInit[i] = idleInit[i];
    end
    if (configMode && cfgIndexWr) begin
      next_cfgIndex = cfgWrData;
    end
    if (dataWrite) begin
      if (cfgIndex == `APM_IDX_ENABLES) begin
        next_pmEnables = cfgWrData & `APM_MASK_ENABLES;
      end else if (cfgIndex == `APM_IDX_ACPI_BASE) begin
        next_acpiBaseReg = cfgWrData & `APM_MASK_ACPI; // see RULE3
      end else if (cfgIndex == `APM_IDX_GP_BASE) begin
        next_gpBaseReg = cfgWrData & `APM_MASK_GP;     // see RULE5
      end else if (cfgIndex == `APM_IDX_UART_A) begin
        next_idleInit[`APM_FN_UART_A] = cfgWrData;
      end else if (cfgIndex == `APM_IDX_UART_B) begin
        next_idleInit[`APM_FN_UART_B] = cfgWrData;
      end else if (cfgIndex == `APM_IDX_FLOPPY) begin
        next_idleInit[`APM_FN_FLOPPY] = cfgWrData;
      end else if (cfgIndex == `APM_IDX_PRINTER) begin
        next_idleInit[`APM_FN_PRINTER] = cfgWrData;
      end else if (cfgIndex == `APM_IDX_STANDBY) begin
        next_standbyInit = cfgWrData;
      end else if (cfgIndex == `APM_IDX_UNIT) begin
        next_unitReg = cfgWrData & `APM_MASK_UNIT;    // see RULE18
      end
    end
  end

  // Status: a set in the same cycle as a write-one clear wins
  always_comb begin
    next_idleSts = idleSts & ~fnWoke;
    next_wakeSts = wakeSts & ~fnExpired;
    if (dataWrite && cfgIndex == `APM_IDX_IDLE_STS) begin
      next_idleSts = next_idleSts & ~cfgWrData[3:0];
    end
    if (dataWrite && cfgIndex == `APM_IDX_WAKE_STS) begin
      next_wakeSts = next_wakeSts & ~cfgWrData[3:0];
    end
    next_idleSts = next_idleSts | fnExpired; // see RULE19
    next_wakeSts = next_wakeSts | fnWoke;    // see RULE20
  end

  // Read data lags the index by one cycle; reads have no side effects
  always_comb begin
    next_cfgRdData = `APM_RST_BYTE;
    if (cfgIndex == `APM_IDX_ENABLES) begin
      next_cfgRdData = pmEnables;
    end else if (cfgIndex == `APM_IDX_ACPI_BASE) begin
      next_cfgRdData = acpiBaseReg;
    end else if (cfgIndex == `APM_IDX_GP_BASE) begin
      next_cfgRdData = gpBaseReg;
    end else if (cfgIndex == `APM_IDX_UART_A) begin
      next_cfgRdData = idleInit[`APM_FN_UART_A];
    end else if (cfgIndex == `APM_IDX_UART_B) begin
      next_cfgRdData = idleInit[`APM_FN_UART_B];
    end else if (cfgIndex == `APM_IDX_FLOPPY) begin
      next_cfgRdData = idleInit[`APM_FN_FLOPPY];
    end else if (cfgIndex == `APM_IDX_PRINTER) begin
      next_cfgRdData = idleInit[`APM_FN_PRINTER];
    end else if (cfgIndex == `APM_IDX_STANDBY) begin
      next_cfgRdData = standbyInit;
    end else if (cfgIndex == `APM_IDX_UNIT) begin
      next_cfgRdData = unitReg;
    end else if (cfgIndex == `APM_IDX_IDLE_STS) begin
      next_cfgRdData = {4'h0, idleSts};
    end else if (cfgIndex == `APM_IDX_WAKE_STS) begin
      next_cfgRdData = {4'h0, wakeSts};
    end
  end

  always_comb begin
    next_acpiEvtBase  = {acpiBaseReg[7:2], 4'h0};
    next_gpe0Base     = {gpBaseReg[7:1], 3'h0};
    next_acpiDecodeEn = chipEnable; // see RULE1
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cfgIndex     <= `APM_RST_BYTE;
      pmEnables    <= `APM_RST_BYTE;
      acpiBaseReg  <= `APM_RST_BYTE;
      gpBaseReg    <= `APM_RST_BYTE;
      standbyInit  <= `APM_RST_BYTE;
      unitReg      <= `APM_RST_BYTE;
      idleSts      <= 4'h0;
      wakeSts      <= 4'h0;
      cfgRdData    <= `APM_RST_BYTE;
      acpiDecodeEn <= 1'b0;
      acpiEvtBase  <= 10'h000;
      acpiCntBase  <= 10'h000;
      acpiTmrBase  <= 10'h000;
      gpe0Base     <= 10'h000;
      gpe1Base     <= 10'h000;
      for (int i = 0; i < `APM_NUM_FN; i++) begin
        idleInit[i] <= `APM_RST_BYTE;
      end
    end else begin
      cfgIndex     <= next_cfgIndex;
      pmEnables    <= next_pmEnables;
      acpiBaseReg  <= next_acpiBaseReg;
      gpBaseReg    <= next_gpBaseReg;
      standbyInit  <= next_standbyInit;
      unitReg      <= next_unitReg;
      idleSts      <= next_idleSts;
      wakeSts      <= next_wakeSts;
      cfgRdData    <= next_cfgRdData;
      acpiDecodeEn <= next_acpiDecodeEn;
      acpiEvtBase  <= next_acpiEvtBase;
      acpiCntBase  <= next_acpiEvtBase + `APM_ACPI_CNT_OFS; // see RULE4
      acpiTmrBase  <= next_acpiEvtBase + `APM_ACPI_TMR_OFS; // see RULE4
      gpe0Base     <= next_gpe0Base;
      gpe1Base     <= next_gpe0Base + `APM_GPE1_OFS;        // see RULE6
      for (int i = 0; i < `APM_NUM_FN; i++) begin
        idleInit[i] <= next_idleInit[i];
      end
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  property p_chip_off_awake; // see RULE1
    !chipEnable |=> (fnSleep == 4'h0);
  endproperty
  a_chip_off_awake: assert property (p_chip_off_awake) else $error("sleep while disabled");

  // Reset leaves all bases at zero, so the offsets only hold one edge after release
  property p_blocks; // see RULE4
    !$past(sys_rst) |->
      (acpiTmrBase == acpiEvtBase + 10'h008 && acpiCntBase == acpiEvtBase + 10'h004);
  endproperty
  a_blocks: assert property (p_blocks) else $error("ACPI block offsets wrong");

  property p_gpe1; // see RULE6
    !$past(sys_rst) |-> (gpe1Base == gpe0Base + 10'h004 && gpe0Base[2:0] == 3'h0);
  endproperty
  a_gpe1: assert property (p_gpe1) else $error("second event block offset wrong");

  property p_idle_set_wins; // see RULE19
    (|fnExpired) |=> ((idleSts & $past(fnExpired)) == $past(fnExpired));
  endproperty
  a_idle_set_wins: assert property (p_idle_set_wins) else $error("idle status lost");

  property p_standby_needs_all; // see RULE15
    !allAsleep |=> !chipSleep;
  endproperty
  a_standby_needs_all: assert property (p_standby_needs_all) else $error("chip slept early");

  property p_fn_off_awake; // see RULE2
    (chipEnable && !pmEnables[`APM_FN_PRINTER]) |=> !fnSleep[`APM_FN_PRINTER];
  endproperty
  a_fn_off_awake: assert property (p_fn_off_awake) else $error("printer slept disabled");

  c_fn_sleep:   cover property (fnExpired[`APM_FN_UART_A]);
  c_fn_wake:    cover property (fnSleep[`APM_FN_FLOPPY] ##1 fnWoke[`APM_FN_FLOPPY]);
  c_chip_sleep: cover property ($rose(chipSleep));
endmodule // apm_power_idle
`default_nettype wire

// >>> verif/apm_host_model.sv
// Host side model: drives the configuration index and data ports.
// Assumes ref_clk comes from the bench; every drive follows a rising edge.
`timescale 1ns/1ps
`default_nettype none
module apm_host_model (
  // Clock
  input  wire logic       ref_clk,
  // Configuration ports
  output logic            configMode,
  output logic            cfgIndexWr,
  output logic            cfgDataWr,
  output logic      [7:0] cfgWrData,
  input  wire logic [7:0] cfgRdData
);
  initial begin
    configMode = 1'b0;
    cfgIndexWr = 1'b0;
    cfgDataWr  = 1'b0;
    cfgWrData  = 8'h00;
  end

  task automatic set_mode(input logic m);
    @(posedge ref_clk);
    configMode <= m;
  endtask

  task automatic set_index(input logic [7:0] idx);
    @(posedge ref_clk);
    cfgIndexWr <= 1'b1;
    cfgWrData  <= idx;
    @(posedge ref_clk);
    cfgIndexWr <= 1'b0;
  endtask

  // Callers keep base values inside 100H..3F0H and 100H..3F8H
  task automatic write_reg(input logic [7:0] idx, input logic [7:0] val);
    set_index(idx);
    cfgDataWr <= 1'b1;
    cfgWrData <= val;
    @(posedge ref_clk);
    cfgDataWr <= 1'b0;
    // Released data lines must not keep showing the last byte
    cfgWrData <= ~val;
  endtask

  // Read path lags two edges behind the index write
  task automatic read_reg(input logic [7:0] idx, output logic [7:0] val);
    set_index(idx);
    repeat (2) @(posedge ref_clk);
    #1 val = cfgRdData;
  endtask
endmodule // apm_host_model
`default_nettype wire

// >>> verif/tb_apm_power_idle.sv
// Self-checking bench for the power management idle timers.
// Assumes the host model file is compiled first; SEC_CYCLES is shortened.
`timescale 1ns/1ps
`default_nettype none
module tb_apm_power_idle;
  localparam int unsigned SEC = 4;
  logic       ref_clk;
  logic       sys_rst;
  logic       configMode;
  logic       cfgIndexWr;
  logic       cfgDataWr;
  logic [7:0] cfgWrData;
  logic [7:0] cfgRdData;
  logic [3:0] fnActivity;
  logic [3:0] fnSleep;
  logic       chipSleep;
  logic       acpiDecodeEn;
  logic [9:0] acpiEvtBase;
  logic [9:0] acpiCntBase;
  logic [9:0] acpiTmrBase;
  logic [9:0] gpe0Base;
  logic [9:0] gpe1Base;
  int         fails;
  int         numChecks;
  int         n;

  apm_host_model host (.ref_clk(ref_clk), .configMode(configMode), .cfgIndexWr(cfgIndexWr),
    .cfgDataWr(cfgDataWr), .cfgWrData(cfgWrData), .cfgRdData(cfgRdData));

  apm_power_idle #(.SEC_CYCLES(SEC)) uut (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .configMode(configMode), .cfgIndexWr(cfgIndexWr), .cfgDataWr(cfgDataWr),
    .cfgWrData(cfgWrData), .cfgRdData(cfgRdData), .fnActivity(fnActivity),
    .fnSleep(fnSleep), .chipSleep(chipSleep), .acpiDecodeEn(acpiDecodeEn),
    .acpiEvtBase(acpiEvtBase), .acpiCntBase(acpiCntBase), .acpiTmrBase(acpiTmrBase),
    .gpe0Base(gpe0Base), .gpe1Base(gpe1Base));

  initial ref_clk = 1'b0;
  always #12.5 ref_clk = ~ref_clk;

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", numChecks, fails);
    if (fails == 0 && numChecks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input logic [9:0] seen, input logic [9:0] exp);
    numChecks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] v;
    host.read_reg(idx, v);
    check({2'b00, v}, {2'b00, exp});
  endtask

  task automatic wake(input logic [3:0] m);
    @(posedge ref_clk);
    fnActivity <= m;
    @(posedge ref_clk);
    fnActivity <= 4'h0;
  endtask

  // Bounded wait for a power state; returns the cycles it took
  task automatic wait_for(input logic [3:0] fe, input logic ce, output int k);
    k = 0;
    #1;
    while ((fnSleep !== fe || chipSleep !== ce) && k < 2000) begin
      @(posedge ref_clk);
      #1;
      k++;
    end
    if (k >= 2000) begin
      fails++;
      $display("mismatch at %0t: state wait ran out", $time);
      give_verdict();
    end
  endtask

  task automatic in_range(input int k, input int lo, input int hi);
    check({9'h000, (k >= lo && k <= hi)}, 10'h001);
  endtask

  initial begin
    fails = 0;
    numChecks = 0;
    sys_rst = 1'b1;
    fnActivity = 4'h0;
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'b0;
    host.set_mode(1'b1);
    for (int i = 0; i < 8; i++) rd(8'h32 + 8'(i), 8'h00);
    rd(8'h39, 8'h00);
    rd(8'h40, 8'h00);
    rd(8'h41, 8'h00);
    rd(8'h50, 8'h00);
    $display("test reset values done");

    host.write_reg(8'h32, 8'hFF);
    host.write_reg(8'h33, 8'hFF);
    host.write_reg(8'h34, 8'hFF);
    host.write_reg(8'h3A, 8'hFF);
    rd(8'h32, 8'h8F);
    rd(8'h33, 8'hFC);
    rd(8'h34, 8'hFE);
    rd(8'h3A, 8'h20);
    check(acpiEvtBase, 10'h3F0);
    check(acpiCntBase, 10'h3F4);
    check(acpiTmrBase, 10'h3F8);
    check(gpe0Base, 10'h3F8);
    check(gpe1Base, 10'h3FC);
    check({9'h000, acpiDecodeEn}, 10'h001);
    host.write_reg(8'h33, 8'h40);
    host.write_reg(8'h34, 8'h40);
    rd(8'h33, 8'h40);
    check(acpiCntBase, 10'h104);
    check(acpiTmrBase, 10'h108);
    check(gpe1Base, 10'h104);
    host.set_mode(1'b0);
    host.write_reg(8'h35, 8'h11);
    host.set_mode(1'b1);
    rd(8'h35, 8'h00);
    $display("test register fields done");

    host.write_reg(8'h3A, 8'h00);
    for (int i = 0; i < 4; i++) host.write_reg(8'h35 + 8'(i), 8'h06);
    host.write_reg(8'h39, 8'h00);
    wake(4'hF);
    wait_for(4'hF, 1'b0, n);
    in_range(n, 20, 26);
    rd(8'h40, 8'h0F);
    rd(8'h41, 8'h00);
    host.write_reg(8'h40, 8'h01);
    rd(8'h40, 8'h0E);
    host.write_reg(8'h40, 8'h00);
    rd(8'h40, 8'h0E);
    wake(4'hF);
    rd(8'h41, 8'h0F);
    repeat (8) @(posedge ref_clk);
    wake(4'hF);
    wait_for(4'hF, 1'b0, n);
    in_range(n, 20, 26);
    $display("test idle timers done");

    host.write_reg(8'h39, 8'h03);
    wake(4'hF);
    wait_for(4'hF, 1'b0, n);
    wait_for(4'hF, 1'b1, n);
    in_range(n, 7, 15);
    wake(4'h1);
    wait_for(4'hE, 1'b0, n);
    in_range(n, 0, 3);
    host.write_reg(8'h32, 8'h0F);
    wait_for(4'h0, 1'b0, n);
    in_range(n, 0, 3);
    check({9'h000, acpiDecodeEn}, 10'h000);
    $display("test standby done");

    host.write_reg(8'h32, 8'h8F);
    for (int i = 0; i < 5; i++) host.write_reg(8'h35 + 8'(i), 8'h00);
    wake(4'hF);
    repeat (40) @(posedge ref_clk);
    #1 check({5'h00, chipSleep, fnSleep}, 10'h000);
    for (int i = 0; i < 4; i++) host.write_reg(8'h35 + 8'(i), 8'h02);
    host.write_reg(8'h32, 8'h85);
    wake(4'hF);
    wait_for(4'h5, 1'b0, n);
    repeat (20) @(posedge ref_clk);
    #1 check({6'h00, fnSleep}, 10'h005);
    $display("test zero count and enables done");

    host.write_reg(8'h32, 8'h8F);
    host.write_reg(8'h3A, 8'h20);
    wake(4'hF);
    repeat (200) @(posedge ref_clk);
    #1 check({6'h00, fnSleep}, 10'h000);
    wait_for(4'hF, 1'b0, n);
    in_range(n, 270, 290);
    $display("test minute unit done");
    give_verdict();
  end
endmodule // tb_apm_power_idle
`default_nettype wire
